// *** verilog/fast_ir_port_pkg.sv ***
// constants shared by the fast infrared port status and fifo logic
package fast_ir_port_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFFSET_CONTROL = 8'h00;
    localparam logic [7:0] OFFSET_DATA = 8'h04;
    localparam logic [7:0] OFFSET_STATUS_PRIMARY = 8'h08;
    localparam logic [7:0] OFFSET_STATUS_SECONDARY = 8'h0c;
    // control register fields
    localparam int CTRL_RECEIVE_ENABLE = 0;
    localparam int CTRL_TRANSMIT_ENABLE = 1;
    localparam int CTRL_RECEIVE_IRQ_ENABLE = 2;
    localparam int CTRL_TRANSMIT_IRQ_ENABLE = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // port_status_primary fields
    localparam int PRI_END_ERROR_IN_FIFO = 0;
    localparam int PRI_UNDERRUN = 1;
    localparam int PRI_RECEIVE_ABORT = 2;
    localparam int PRI_TRANSMIT_SERVICE = 3;
    localparam int PRI_RECEIVE_SERVICE = 4;
    localparam int PRI_FRAMING_ERROR = 5;
    // port_status_secondary fields
    localparam int SEC_RECEIVER_LOCKED = 0;
    localparam int SEC_TRANSMITTER_ACTIVE = 1;
    localparam int SEC_RECEIVE_NOT_EMPTY = 2;
    localparam int SEC_TRANSMIT_NOT_FULL = 3;
    localparam int SEC_END_OF_FRAME = 4;
    localparam int SEC_CRC_ERROR = 5;
    // hidden receive fifo tag positions
    localparam int TAG_END_OF_FRAME = 8;
    localparam int TAG_CRC_ERROR = 9;
    localparam int TAG_OVERRUN = 10;
    localparam int RX_ENTRY_W = 11;
    localparam int TX_ENTRY_W = 8;
    // sizes and thresholds
    localparam int TX_DEPTH_DEFAULT = 16;
    localparam int RX_DEPTH_DEFAULT = 16;
    localparam int RX_TRIGGER_DEFAULT = 12;
    localparam int TX_SERVICE_MAX = 8;
    localparam int EOF_WINDOW = 8;
    localparam logic STATUS_RESET = 1'b0;
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage

// *** verilog/fast_ir_tag_fifo.sv ***
// shift-down fifo: entry 0 is the bottom, tags ride along with their data
`timescale 1ns/1ps
module fast_ir_tag_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_push_data,
    input wire logic i_pop,
    input wire logic i_mark,
    input wire logic [WIDTH-1:0] i_mark_bits,
    output logic [CW-1:0] o_count,
    output logic [DEPTH-1:0][WIDTH-1:0] o_entries
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0] count;
    } fifo_state_type;

    fifo_state_type state;
    fifo_state_type next_state;
    logic do_pop;
    logic do_push;

    if (DEPTH < 2) begin : g_depth_check
        $error("fifo depth must be at least two");
    end

    always_comb begin
        next_state = state;
        do_pop = i_pop && (state.count != '0);
        do_push = i_push && ((state.count != CW'(DEPTH)) || do_pop);
        // mark lands on the newest stored entry, before any shift
        if (i_mark && (state.count != '0)) begin
            next_state.mem[CW'(state.count - 1'b1)] = state.mem[CW'(state.count - 1'b1)] | i_mark_bits;
        end
        if (do_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_state.mem[i] = next_state.mem[i + 1];
            end
            next_state.mem[DEPTH-1] = '0;
        end
        if (do_push) begin
            next_state.mem[CW'(state.count - CW'(do_pop))] = i_push_data;
        end
        next_state.count = CW'(state.count + CW'(do_push) - CW'(do_pop));
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_count = state.count;
    assign o_entries = state.mem;
endmodule

// *** verilog/fast_ir_port_status.sv ***
// status flags, fifo tags and register access of the fast infrared port
// Functional notes
// R01: abort chips set receive abort, tag end of frame on last good byte, interrupt.
// R02: transmit service, dma and masked irq while tx fifo holds eight or fewer, enabled.
// R03: receive service, dma and masked irq at trigger level while receiver enabled.
// R04: preamble followed by neither preamble nor start flag sets framing error, interrupt.
// R05: receiver locked flag high while synchronized, low in hunt or disabled, no irq.
// R06: transmitter active flag high while sending a frame part, low idle or disabled.
// R07: receive not empty set while any valid byte is in the receive fifo.
// R08: transmit not full set while any transmit entry is free.
// R09: each receive entry carries three hidden tag bits at 8, 9 and 10.
// R10: last byte of a frame enters the fifo with its end of frame tag.
// R11: end of frame flag copies the bottom entry tag on every move down.
// R12: end tag in bottom eight entries sets end/error in fifo, irq, blocks rx dma.
// R13: crc mismatch sets the crc tag on the frame's last byte entry.
// R14: crc error flag copies the bottom entry crc tag on every move down.
// R15: crc tag in bottom half sets end/error in fifo, irq, blocks rx dma.
// R16: software reads the secondary status before each data read after end/error.
// R17: dma or irq only at trigger level; programmed reads poll receive not empty.
// R18: secondary status raises no interrupt and is read only.
// R19: writable primary status bits clear on writing one.
// R20: no tags in the bottom eight entries clears end/error and re-enables rx dma.
// R21: secondary bits: locked 0, active 1, not empty 2, not full 3, eof 4, crc 5.
// R22: fifo derived flags follow the fifo contents in the same cycle.
`timescale 1ns/1ps
module fast_ir_port_status import fast_ir_port_pkg::*; #(
    parameter int TX_DEPTH = TX_DEPTH_DEFAULT,
    parameter int RX_DEPTH = RX_DEPTH_DEFAULT,
    parameter int RX_TRIGGER = RX_TRIGGER_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic i_rx_byte_valid,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_last,
    input wire logic i_rx_crc_bad,
    input wire logic i_rx_abort,
    input wire logic i_rx_framing_error,
    input wire logic i_rx_locked,
    input wire logic i_tx_frame_active,
    input wire logic i_tx_take,
    output logic [7:0] o_rd_data,
    output logic [7:0] o_tx_byte,
    output logic o_tx_byte_valid,
    output logic o_rx_dma_req,
    output logic o_tx_dma_req,
    output logic o_irq,
    output logic o_receive_enable,
    output logic o_transmit_enable
);
    localparam int TXC_W = $clog2(TX_DEPTH + 1);
    localparam int RXC_W = $clog2(RX_DEPTH + 1);

    if ((RX_DEPTH < EOF_WINDOW) || (RX_TRIGGER < 1) || (RX_TRIGGER > RX_DEPTH)
        || (TX_DEPTH <= TX_SERVICE_MAX)) begin : g_param_check
        $error("fifo depths or receive trigger out of range");
    end

    typedef struct packed {
        logic [3:0] ctrl;
        logic receive_abort_status;
        logic framing_error_status;
        logic [7:0] rd_data;
        logic irq;
        logic rx_dma;
        logic tx_dma;
        logic tx_valid;
    } state_type;

    state_type state;
    state_type next_state;

    logic [TXC_W-1:0] tx_count;
    logic [TX_DEPTH-1:0][TX_ENTRY_W-1:0] tx_entries;
    logic [RXC_W-1:0] rx_count;
    logic [RX_DEPTH-1:0][RX_ENTRY_W-1:0] rx_entries;
    logic rx_push;
    logic [RX_ENTRY_W-1:0] rx_push_entry;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
    logic [TXC_W-1:0] tx_count_next;
    logic receive_enable;
    logic transmit_enable;
    logic transmit_service_status;
    logic receive_service_status;
    logic end_error_in_fifo;
    logic receiver_locked_flag;
    logic transmitter_active_flag;
    logic receive_not_empty_flag;
    logic transmit_not_full_flag;
    logic end_of_frame_flag;
    logic crc_error_flag;
    logic [7:0] status_primary;
    logic [7:0] status_secondary;

    // true when a tag bit is set in any of the lowest window entries
    function automatic logic tag_in_window(input logic [RX_DEPTH-1:0][RX_ENTRY_W-1:0] entries,
                                           input int tag_bit, input int window);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < RX_DEPTH; i++) begin
            if (i < window) begin
                hit = hit | entries[i][tag_bit];
            end
        end
        return hit;
    endfunction

    assign receive_enable = state.ctrl[CTRL_RECEIVE_ENABLE];
    assign transmit_enable = state.ctrl[CTRL_TRANSMIT_ENABLE];

    // data register access: a read drains the bottom entry, a write fills the tx fifo
    assign rx_pop = i_rd_en && (i_addr == OFFSET_DATA);
    assign tx_push = i_wr_en && (i_addr == OFFSET_DATA);
    assign rx_push = i_rx_byte_valid && receive_enable;
    // mirrors the tx fifo count so that the byte valid output can leave from a flop
    assign tx_pop = i_tx_take && transmit_enable && (tx_count != '0);
    assign tx_count_next = TXC_W'(tx_count + TXC_W'(tx_push && ((tx_count != TXC_W'(TX_DEPTH)) || tx_pop))
        - TXC_W'(tx_pop));
    // hidden tags sit above the data byte
    always_comb begin
        rx_push_entry = '0; // R09
        rx_push_entry[7:0] = i_rx_byte;
        rx_push_entry[TAG_END_OF_FRAME] = i_rx_last; // R10
        rx_push_entry[TAG_CRC_ERROR] = i_rx_last && i_rx_crc_bad; // R13
    end

    // writes into a full fifo are dropped unless a read pops in the same cycle; nothing sets the overrun tag
    fast_ir_tag_fifo #(
        .WIDTH(RX_ENTRY_W),
        .DEPTH(RX_DEPTH),
        .CW(RXC_W)
    ) u_rx_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_push(rx_push),
        .i_push_data(rx_push_entry),
        .i_pop(rx_pop),
        .i_mark(i_rx_abort),
        .i_mark_bits(RX_ENTRY_W'(1 << TAG_END_OF_FRAME)), // R01
        .o_count(rx_count),
        .o_entries(rx_entries)
    );

    fast_ir_tag_fifo #(
        .WIDTH(TX_ENTRY_W),
        .DEPTH(TX_DEPTH),
        .CW(TXC_W)
    ) u_tx_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_push(tx_push),
        .i_push_data(i_wr_data),
        .i_pop(tx_pop),
        .i_mark(1'b0),
        .i_mark_bits('0),
        .o_count(tx_count),
        .o_entries(tx_entries)
    );

    // flags read straight from the fifo flops, so a read never sees stale state
    always_comb begin
        end_error_in_fifo = tag_in_window(rx_entries, TAG_END_OF_FRAME, EOF_WINDOW) // R12 R20 R22
            | tag_in_window(rx_entries, TAG_CRC_ERROR, RX_DEPTH / 2) // R15
            | tag_in_window(rx_entries, TAG_OVERRUN, EOF_WINDOW);
        transmit_service_status = transmit_enable && (tx_count <= TXC_W'(TX_SERVICE_MAX)); // R02
        receive_service_status = receive_enable && (rx_count >= RXC_W'(RX_TRIGGER)); // R03 R17
        receiver_locked_flag = receive_enable && i_rx_locked; // R05
        transmitter_active_flag = transmit_enable && i_tx_frame_active; // R06
        receive_not_empty_flag = (rx_count != '0); // R07
        transmit_not_full_flag = (tx_count != TXC_W'(TX_DEPTH)); // R08
        end_of_frame_flag = receive_not_empty_flag && rx_entries[0][TAG_END_OF_FRAME]; // R11
        crc_error_flag = receive_not_empty_flag && rx_entries[0][TAG_CRC_ERROR]; // R14
        status_primary = '0;
        status_primary[PRI_END_ERROR_IN_FIFO] = end_error_in_fifo;
        status_primary[PRI_RECEIVE_ABORT] = state.receive_abort_status;
        status_primary[PRI_TRANSMIT_SERVICE] = transmit_service_status;
        status_primary[PRI_RECEIVE_SERVICE] = receive_service_status;
        status_primary[PRI_FRAMING_ERROR] = state.framing_error_status;
        status_secondary = '0; // R18
        status_secondary[SEC_RECEIVER_LOCKED] = receiver_locked_flag; // R21
        status_secondary[SEC_TRANSMITTER_ACTIVE] = transmitter_active_flag;
        status_secondary[SEC_RECEIVE_NOT_EMPTY] = receive_not_empty_flag;
        status_secondary[SEC_TRANSMIT_NOT_FULL] = transmit_not_full_flag;
        status_secondary[SEC_END_OF_FRAME] = end_of_frame_flag;
        status_secondary[SEC_CRC_ERROR] = crc_error_flag;
    end

    always_comb begin
        next_state = state;
        next_state.rd_data = READ_IDLE;
        if (i_wr_en) begin
            if (i_addr == OFFSET_CONTROL) begin
                next_state.ctrl = i_wr_data[3:0];
            end else if (i_addr == OFFSET_STATUS_PRIMARY) begin
                // write one to clear; an event in the same cycle is applied after and wins
                if (i_wr_data[PRI_RECEIVE_ABORT]) begin
                    next_state.receive_abort_status = 1'b0; // R19
                end
                if (i_wr_data[PRI_FRAMING_ERROR]) begin
                    next_state.framing_error_status = 1'b0; // R19
                end
            end
        end
        if (i_rx_abort) begin
            next_state.receive_abort_status = 1'b1; // R01
        end
        if (i_rx_framing_error) begin
            next_state.framing_error_status = 1'b1; // R04
        end
        if (i_rd_en) begin
            if (i_addr == OFFSET_CONTROL) begin
                next_state.rd_data = {4'h0, state.ctrl};
            end else if (i_addr == OFFSET_DATA) begin
                next_state.rd_data = rx_entries[0][7:0];
            end else if (i_addr == OFFSET_STATUS_PRIMARY) begin
                next_state.rd_data = status_primary;
            end else if (i_addr == OFFSET_STATUS_SECONDARY) begin
                next_state.rd_data = status_secondary; // R16
            end else begin
                next_state.rd_data = READ_IDLE;
            end
        end
        // the end/error condition holds off receive dma until the tags leave the window
        next_state.rx_dma = receive_service_status && !end_error_in_fifo; // R03 R12 R15 R20
        next_state.tx_dma = transmit_service_status; // R02
        next_state.tx_valid = next_state.ctrl[CTRL_TRANSMIT_ENABLE] && (tx_count_next != '0);
        // secondary status flags deliberately take no part in the interrupt
        next_state.irq = state.receive_abort_status || state.framing_error_status || end_error_in_fifo // R18
            || (transmit_service_status && state.ctrl[CTRL_TRANSMIT_IRQ_ENABLE])
            || (receive_service_status && state.ctrl[CTRL_RECEIVE_IRQ_ENABLE]);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= '{ctrl: CTRL_RESET, receive_abort_status: STATUS_RESET, framing_error_status: STATUS_RESET,
                       rd_data: READ_IDLE, irq: 1'b0, rx_dma: 1'b0, tx_dma: 1'b0, tx_valid: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign o_rd_data = state.rd_data;
    assign o_tx_byte = tx_entries[0];
    assign o_tx_byte_valid = state.tx_valid;
    assign o_rx_dma_req = state.rx_dma;
    assign o_tx_dma_req = state.tx_dma;
    assign o_irq = state.irq;
    assign o_receive_enable = receive_enable;
    assign o_transmit_enable = transmit_enable;

    // checks
    sequence last_byte_into_empty_s;
        i_rx_byte_valid && receive_enable && i_rx_last && (rx_count == '0) && !rx_pop;
    endsequence

    sequence bottom_shows_eof_s;
        receive_not_empty_flag && end_of_frame_flag;
    endsequence

    sequence clear_abort_alone_s;
        i_wr_en && (i_addr == OFFSET_STATUS_PRIMARY) && i_wr_data[PRI_RECEIVE_ABORT] && !i_rx_abort;
    endsequence

    sequence pop_onto_eof_s;
        rx_pop && (rx_count >= RXC_W'(2)) && rx_entries[1][TAG_END_OF_FRAME];
    endsequence

    sequence pop_onto_crc_s;
        rx_pop && (rx_count >= RXC_W'(2)) && rx_entries[1][TAG_CRC_ERROR];
    endsequence

    abort_sets_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R01
        i_rx_abort |=> state.receive_abort_status ##1 o_irq)
        else $error("abort did not set status and interrupt");

    tx_service_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R02
        ##1 (o_tx_dma_req == $past(transmit_enable && (tx_count <= TXC_W'(TX_SERVICE_MAX)))))
        else $error("transmit dma request does not follow fifo level");

    rx_service_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R03
        o_rx_dma_req |-> $past(receive_enable) && ($past(rx_count) >= RXC_W'(RX_TRIGGER)))
        else $error("receive dma request without trigger level");

    framing_sets_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R04
        i_rx_framing_error |=> state.framing_error_status ##1 o_irq)
        else $error("framing error not recorded");

    locked_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R05
        !receive_enable |-> !status_secondary[SEC_RECEIVER_LOCKED])
        else $error("locked flag high while receiver disabled");

    not_empty_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R07
        (rx_count == '0) |=> (rx_count != '0) == $past(rx_push))
        else $error("receive fifo fill does not match push");

    eof_travel_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R11
        last_byte_into_empty_s |=> bottom_shows_eof_s ##0 end_error_in_fifo)
        else $error("end of frame tag did not reach bottom flag");

    eif_blocks_dma_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R12
        $past(end_error_in_fifo) |-> !o_rx_dma_req)
        else $error("receive dma requested with end or error in fifo");

    abort_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R19
        clear_abort_alone_s |=> !state.receive_abort_status)
        else $error("write one did not clear receive abort");

    secondary_ro_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R18
        (i_rd_en && (i_addr == OFFSET_STATUS_SECONDARY)) |=> (o_rd_data[7:6] == 2'b00))
        else $error("secondary status reserved bits not zero");

    eof_bottom_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R11
        pop_onto_eof_s |=> status_secondary[SEC_END_OF_FRAME])
        else $error("end of frame flag missed the tagged byte");

    crc_bottom_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R14
        pop_onto_crc_s |=> status_secondary[SEC_CRC_ERROR])
        else $error("crc error flag missed the tagged byte");

    tx_busy_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R06
        !transmit_enable |-> !status_secondary[SEC_TRANSMITTER_ACTIVE])
        else $error("transmitter active while disabled");

    tx_full_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R08
        (tx_count == TXC_W'(TX_DEPTH)) |-> !status_secondary[SEC_TRANSMIT_NOT_FULL])
        else $error("transmit not full while full");

    no_tags_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R20
        (rx_count == '0) |-> !end_error_in_fifo)
        else $error("end or error flagged with empty fifo");

    rx_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R03
        !receive_enable |=> !o_rx_dma_req)
        else $error("receive dma request while disabled");

    tx_valid_a: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R22
        o_tx_byte_valid == (o_transmit_enable && (tx_count != '0)))
        else $error("transmit byte valid does not follow fifo");
endmodule

// *** dv/fast_ir_link_model.sv ***
// behavioural receive and transmit engine on the far side of the port status block
`timescale 1ns/1ps
module fast_ir_link_model (
    input wire logic i_clk,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_byte_valid,
    output logic o_rx_byte_valid,
    output logic [7:0] o_rx_byte,
    output logic o_rx_last,
    output logic o_rx_crc_bad,
    output logic o_rx_abort,
    output logic o_rx_framing_error,
    output logic o_rx_locked,
    output logic o_tx_frame_active,
    output logic o_tx_take
);
    initial begin
        o_rx_byte_valid = 1'b0;
        o_rx_byte = 8'h00;
        o_rx_last = 1'b0;
        o_rx_crc_bad = 1'b0;
        o_rx_abort = 1'b0;
        o_rx_framing_error = 1'b0;
        o_rx_locked = 1'b0;
        o_tx_frame_active = 1'b0;
        o_tx_take = 1'b0;
    end
    // one byte per strobe; qualifiers are inverted outside it so stale values never look valid
    task automatic send(input logic [7:0] b, input logic last, input logic crc);
        @(posedge i_clk);
        o_rx_byte_valid <= 1'b1;
        o_rx_byte <= b;
        o_rx_last <= last;
        o_rx_crc_bad <= crc;
        @(posedge i_clk);
        o_rx_byte_valid <= 1'b0;
        o_rx_byte <= ~b;
        o_rx_last <= ~last;
        o_rx_crc_bad <= ~crc;
    endtask
    // abort chips or a broken preamble seen on the line, one cycle each
    task automatic pulse(input logic abort);
        @(posedge i_clk);
        o_rx_abort <= abort;
        o_rx_framing_error <= ~abort;
        @(posedge i_clk);
        o_rx_abort <= 1'b0;
        o_rx_framing_error <= 1'b0;
    endtask
    task automatic levels(input logic locked, input logic active);
        @(posedge i_clk);
        o_rx_locked <= locked;
        o_tx_frame_active <= active;
    endtask
    // the byte is taken at the edge that pops it; nothing offered reads as unknown
    task automatic take(output logic [7:0] b);
        @(posedge i_clk);
        o_tx_take <= 1'b1;
        @(posedge i_clk);
        b = i_tx_byte_valid ? i_tx_byte : 8'hxx;
        o_tx_take <= 1'b0;
    endtask
endmodule

// *** dv/tb_fast_ir_port_status.sv ***
// self-checking bench of the fast infrared port status block
`timescale 1ns/1ps
module tb_fast_ir_port_status import fast_ir_port_pkg::*;;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [7:0] i_wr_data = 8'h00;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic rx_valid, rx_last, rx_crc, rx_abort, rx_fr, rx_lock, tx_act, tx_take;
    logic [7:0] rx_byte, o_rd_data, tx_byte, b;
    logic tx_valid, rx_dma, tx_dma, irq, rx_en, tx_en;
    int error_cnt = 0;
    int compares = 0;
    always #20 i_clk = ~i_clk;
    fast_ir_port_status i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_rx_byte_valid(rx_valid),
        .i_rx_byte(rx_byte), .i_rx_last(rx_last), .i_rx_crc_bad(rx_crc), .i_rx_abort(rx_abort),
        .i_rx_framing_error(rx_fr), .i_rx_locked(rx_lock), .i_tx_frame_active(tx_act),
        .i_tx_take(tx_take), .o_rd_data(o_rd_data), .o_tx_byte(tx_byte), .o_tx_byte_valid(tx_valid),
        .o_rx_dma_req(rx_dma), .o_tx_dma_req(tx_dma), .o_irq(irq), .o_receive_enable(rx_en),
        .o_transmit_enable(tx_en));
    fast_ir_link_model i_model (.i_clk(i_clk), .i_tx_byte(tx_byte), .i_tx_byte_valid(tx_valid),
        .o_rx_byte_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_last(rx_last), .o_rx_crc_bad(rx_crc),
        .o_rx_abort(rx_abort), .o_rx_framing_error(rx_fr), .o_rx_locked(rx_lock),
        .o_tx_frame_active(tx_act), .o_tx_take(tx_take));
    task automatic conclude();
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask
    // idle first so every flag has settled before the strobe edge
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        repeat (3) @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1;
        chk8(n, e, o_rd_data);
    endtask
    initial begin
        #(40 * 20000);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h08);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
        rdchk("unmapped", 8'h10, 8'h00);
        wr(OFFSET_CONTROL, 8'h0f);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h08);
        chk8("tx dma", 8'h01, {7'h00, tx_dma});
        chk8("irq", 8'h01, {7'h00, irq});
        for (int i = 0; i < 17; i++) begin
            wr(OFFSET_DATA, 8'h40 + i[7:0]);
            if (i == 7) rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h08);
            if (i == 8) rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
            if (i == 8) chk8("tx dma", 8'h00, {7'h00, tx_dma});
            if (i == 14) rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h08);
        end
        i_model.levels(1'b0, 1'b1);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h02);
        chk8("tx valid", 8'h01, {7'h00, tx_valid});
        for (int i = 0; i < 16; i++) begin
            i_model.take(b);
            chk8("tx byte", 8'h40 + i[7:0], b);
        end
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h0a);
        chk8("tx valid", 8'h00, {7'h00, tx_valid});
        wr(OFFSET_CONTROL, 8'h0d);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h08);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
        rdchk("control", OFFSET_CONTROL, 8'h0d);
        i_model.levels(1'b1, 1'b0);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h09);
        chk8("irq", 8'h00, {7'h00, irq});
        i_model.levels(1'b0, 1'b0);
        // last byte lands in entry 11, beyond the tag window, so only the trigger shows
        for (int i = 0; i < 12; i++) begin
            i_model.send(8'h80 + i[7:0], i == 11, i == 11);
            if (i == 10) rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
        end
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h10);
        chk8("rx dma", 8'h01, {7'h00, rx_dma});
        chk8("irq", 8'h01, {7'h00, irq});
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h0c);
        for (int j = 0; j < 4; j++) rdchk("rx data", OFFSET_DATA, 8'h80 + j[7:0]);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h01);
        chk8("rx dma", 8'h00, {7'h00, rx_dma});
        chk8("irq", 8'h01, {7'h00, irq});
        for (int j = 4; j < 11; j++) rdchk("rx data", OFFSET_DATA, 8'h80 + j[7:0]);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h3c);
        rdchk("rx data", OFFSET_DATA, 8'h8b);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
        wr(OFFSET_CONTROL, 8'h0c);
        i_model.levels(1'b1, 1'b0);
        i_model.send(8'h55, 1'b0, 1'b0);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h08);
        i_model.levels(1'b0, 1'b0);
        wr(OFFSET_CONTROL, 8'h0d);
        i_model.send(8'h11, 1'b0, 1'b0);
        i_model.send(8'h22, 1'b0, 1'b0);
        i_model.pulse(1'b1);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h05);
        chk8("irq", 8'h01, {7'h00, irq});
        wr(OFFSET_STATUS_PRIMARY, 8'h04);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h01);
        rdchk("rx data", OFFSET_DATA, 8'h11);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h1c);
        rdchk("rx data", OFFSET_DATA, 8'h22);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
        i_model.pulse(1'b0);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h20);
        chk8("irq", 8'h01, {7'h00, irq});
        wr(OFFSET_STATUS_PRIMARY, 8'h20);
        rdchk("primary", OFFSET_STATUS_PRIMARY, 8'h00);
        chk8("irq", 8'h00, {7'h00, irq});
        wr(OFFSET_STATUS_SECONDARY, 8'hff);
        rdchk("secondary", OFFSET_STATUS_SECONDARY, 8'h08);
        chk8("enables", 8'h01, {6'h00, tx_en, rx_en});
        conclude();
    end
endmodule
